// ===== pwt_pkg.sv
// constants shared by both ends of the power enable and wake-up timer link
// assumes one 200 MHz clock per end and a three-wire serial link between them
// Function
// - code 10000010b loads the power enable word
// - code 111b loads wake-up exponent and multiplier
// - power word resets to 0x8208
// - interval word resets to 0xE196
// - bit 7 switches the receive chain
// - receive chain includes baseband, synthesizer, oscillator
// - baseband needs oscillator enable set too
// - bit 5 switches transmit chain and transmission
// - bit 4 switches the synthesizer
// - bit 3 switches the crystal oscillator
// - bit 2 switches the battery detector
// - bit 1 switches the wake-up timer
// - bit 0 low runs clock output
// - running clock output keeps oscillator, blocks sleep
// - host writes exponent 0 to 29 only
// - host writes multiplier 0 to 255
// - interval is 1.03 ms times m times 2^e plus 0.5 ms
// - host clears then sets timer enable to rearm
package pwt_pkg;

  // ==========================================================
  // command words
  localparam int          WORD_W          = 16;
  localparam int          CODE_HI         = 15;
  localparam int          POWER_CODE_LO   = 8;
  localparam int          INTERVAL_CODE_LO = 13;
  localparam logic [7:0]  POWER_CODE      = 8'h82;
  localparam logic [2:0]  INTERVAL_CODE   = 3'h7;
  localparam logic [15:0] POWER_RESET     = 16'h8208;
  localparam logic [15:0] INTERVAL_RESET  = 16'hE196;

  // ==========================================================
  // power word fields
  localparam int BIT_RX     = 7;
  localparam int BIT_BB     = 6;
  localparam int BIT_TX     = 5;
  localparam int BIT_SYN    = 4;
  localparam int BIT_OSC    = 3;
  localparam int BIT_LBD    = 2;
  localparam int BIT_WUT    = 1;
  localparam int BIT_CLKDIS = 0;

  // ==========================================================
  // interval word fields
  localparam int         EXP_HI  = 12;
  localparam int         EXP_LO  = 8;
  localparam int         MUL_HI  = 7;
  localparam int         MUL_LO  = 0;
  localparam logic [4:0] EXP_MAX = 5'h1D;
  localparam int         TIMER_W = 40;
  localparam int         CYC_W   = 32;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int TICK_TIME_NS    = 1030000;
  localparam int OFFSET_TIME_NS  = 500000;
  localparam int TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int OFFSET_CYCLES   = OFFSET_TIME_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYCLES = 8;
  localparam int BIT_CNT_W       = 5;
  localparam logic [4:0] LAST_BIT   = 5'h0F;
  localparam logic [4:0] WORD_BITS  = 5'h10;

  // ==========================================================
  // host registers on the Avalon side
  localparam int         ADDR_W          = 4;
  localparam logic [3:0] REG_CMD         = 4'h0;
  localparam logic [3:0] REG_STATUS      = 4'h4;
  localparam logic [3:0] REG_REARM       = 4'h8;
  localparam logic [3:0] REG_LAST_POWER  = 4'hC;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_LOW  = 2'h1,
    LINK_HIGH = 2'h3,
    LINK_END  = 2'h2
  } pwt_link_state_type;

  typedef enum logic [1:0] {
    TIMER_IDLE   = 2'h0,
    TIMER_OFFSET = 2'h1,
    TIMER_COUNT  = 2'h3,
    TIMER_DONE   = 2'h2
  } pwt_timer_state_type;

endpackage

// ===== pwt_link_if.sv
// serial command link between host and device
// assumes the testbench instantiates it and hands one modport to each end
`timescale 1ns/1ps
`default_nettype none
interface pwt_link_if;
  logic sck;
  logic sdi;
  logic select_n;
  modport host (output sck, output sdi, output select_n);
  modport dev  (input sck, input sdi, input select_n);
endinterface
`default_nettype wire

// ===== pwt_device.sv
// device end: command shifter, power enables and wake-up timer
// assumes link pins asynchronous to CLOCK; TX_DATA_REG_ON on CLOCK
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pwt_device
  import pwt_pkg::*;
#(
  parameter int TICK_CYCLES_P   = TICK_CYCLES,
  parameter int OFFSET_CYCLES_P = OFFSET_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  pwt_link_if.dev          LINK,
  input  wire logic        TX_DATA_REG_ON,
  output logic             RX_CHAIN_ON,
  output logic             BASEBAND_ON,
  output logic             TX_CHAIN_ON,
  output logic             TX_SENDING,
  output logic             SYNTH_ON,
  output logic             CRYSTAL_OSC_RUN,
  output logic             BATTERY_DET_ON,
  output logic             WAKEUP_TIMER_ON,
  output logic             CLOCK_OUT_RUN,
  output logic             FULL_SLEEP,
  output logic             WAKEUP_EVENT,
  output logic [15:0]      POWER_WORD,
  output logic [15:0]      INTERVAL_WORD
);

  // ==========================================================
  // pin synchronisers
  logic [1:0]            sck_sync_reg;
  logic [1:0]            sdi_sync_reg;
  logic [1:0]            sel_n_sync_reg;
  logic                  sck_last_reg;
  logic                  sck_rise;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sck_sync_reg   <= 2'h0;
      sdi_sync_reg   <= 2'h0;
      sel_n_sync_reg <= 2'h3;
      sck_last_reg   <= 1'b0;
    end else begin
      sck_sync_reg   <= {sck_sync_reg[0], LINK.sck};
      sdi_sync_reg   <= {sdi_sync_reg[0], LINK.sdi};
      sel_n_sync_reg <= {sel_n_sync_reg[0], LINK.select_n};
      sck_last_reg   <= sck_sync_reg[1];
    end
  end

  assign sck_rise = sck_sync_reg[1] && !sck_last_reg;

  // ==========================================================
  // command shifter
  logic [WORD_W-1:0]     shift_reg;
  logic [BIT_CNT_W-1:0]  bit_cnt_reg;
  logic [WORD_W-1:0]     word_next;
  logic                  word_strobe;
  logic                  selected;

  assign selected    = !sel_n_sync_reg[1];
  assign word_next   = {shift_reg[WORD_W-2:0], sdi_sync_reg[1]};
  // a word counts only on its sixteenth clock inside one select
  assign word_strobe = selected && sck_rise && bit_cnt_reg == LAST_BIT;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (!selected) begin
      bit_cnt_reg <= '0;
    end else if (sck_rise && bit_cnt_reg != WORD_BITS) begin
      // extra clocks after sixteen bits are ignored until deselect
      shift_reg   <= word_next;
      bit_cnt_reg <= bit_cnt_reg + BIT_CNT_W'(1);
    end
  end

  // ==========================================================
  // command registers
  logic [WORD_W-1:0]     power_word_reg;
  logic [WORD_W-1:0]     interval_word_reg;
  logic                  is_power;
  logic                  is_interval;

  assign is_power    = word_next[CODE_HI:POWER_CODE_LO] == POWER_CODE;
  assign is_interval = word_next[CODE_HI:INTERVAL_CODE_LO] == INTERVAL_CODE;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      power_word_reg <= POWER_RESET;
    end else if (word_strobe && is_power) begin
      power_word_reg <= word_next;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      interval_word_reg <= INTERVAL_RESET;
    end else if (word_strobe && is_interval) begin
      interval_word_reg <= word_next;
    end
  end

  // ==========================================================
  // resource enables
  logic                  rx_on;
  logic                  bb_on;
  logic                  tx_on;
  logic                  syn_on;
  logic                  osc_run;
  logic                  lbd_on;
  logic                  clk_out_on;

  assign rx_on      = power_word_reg[BIT_RX];
  // receive chain pulls in its own baseband, synthesizer, oscillator
  assign bb_on      = power_word_reg[BIT_BB] || rx_on;
  assign tx_on      = power_word_reg[BIT_TX];
  assign syn_on     = power_word_reg[BIT_SYN] || rx_on || tx_on;
  assign clk_out_on = !power_word_reg[BIT_CLKDIS];
  // clock output holds the oscillator up even with its enable off
  assign osc_run    = power_word_reg[BIT_OSC] || rx_on || tx_on ||
                      clk_out_on;
  assign lbd_on     = power_word_reg[BIT_LBD];

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RX_CHAIN_ON     <= 1'b0;
      BASEBAND_ON     <= 1'b0;
      TX_CHAIN_ON     <= 1'b0;
      TX_SENDING      <= 1'b0;
      SYNTH_ON        <= 1'b0;
      CRYSTAL_OSC_RUN <= 1'b0;
      BATTERY_DET_ON  <= 1'b0;
      WAKEUP_TIMER_ON <= 1'b0;
      CLOCK_OUT_RUN   <= 1'b0;
      FULL_SLEEP      <= 1'b0;
      POWER_WORD      <= POWER_RESET;
      INTERVAL_WORD   <= INTERVAL_RESET;
    end else begin
      RX_CHAIN_ON     <= rx_on;
      BASEBAND_ON     <= bb_on;
      TX_CHAIN_ON     <= tx_on;
      TX_SENDING      <= tx_on && TX_DATA_REG_ON;
      SYNTH_ON        <= syn_on;
      CRYSTAL_OSC_RUN <= osc_run;
      BATTERY_DET_ON  <= lbd_on;
      WAKEUP_TIMER_ON <= power_word_reg[BIT_WUT];
      CLOCK_OUT_RUN   <= clk_out_on;
      // the wake-up timer alone does not keep the part awake
      FULL_SLEEP      <= !(osc_run || bb_on || syn_on || lbd_on);
      POWER_WORD      <= power_word_reg;
      INTERVAL_WORD   <= interval_word_reg;
    end
  end

  // ==========================================================
  // wake-up timer
  pwt_timer_state_type   timer_state_reg;
  logic                  wut_last_reg;
  logic                  wut_rise;
  logic [CYC_W-1:0]      cyc_reg;
  logic [TIMER_W-1:0]    ticks_reg;
  logic [TIMER_W-1:0]    target;

  assign wut_rise = power_word_reg[BIT_WUT] && !wut_last_reg;
  // multiplier shifted by exponent gives the count of 1.03 ms ticks
  assign target   = TIMER_W'(interval_word_reg[MUL_HI:MUL_LO]) <<
                    interval_word_reg[EXP_HI:EXP_LO];

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wut_last_reg <= 1'b0;
    end else begin
      wut_last_reg <= power_word_reg[BIT_WUT];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      timer_state_reg <= TIMER_IDLE;
      cyc_reg         <= '0;
      ticks_reg       <= '0;
      WAKEUP_EVENT    <= 1'b0;
    end else begin
      WAKEUP_EVENT <= 1'b0;
      if (!power_word_reg[BIT_WUT]) begin
        timer_state_reg <= TIMER_IDLE;
      end else if (wut_rise) begin
        timer_state_reg <= TIMER_OFFSET;
        cyc_reg         <= '0;
        ticks_reg       <= '0;
      end else begin
        case (timer_state_reg)
          TIMER_OFFSET: begin
            // fixed 0.5 ms lead before the scaled part
            if (cyc_reg == CYC_W'(OFFSET_CYCLES_P - 1)) begin
              timer_state_reg <= TIMER_COUNT;
              cyc_reg         <= '0;
            end else begin
              cyc_reg <= cyc_reg + CYC_W'(1);
            end
          end
          TIMER_COUNT: begin
            if (ticks_reg >= target) begin
              // single shot; host must toggle the enable to go again
              timer_state_reg <= TIMER_DONE;
              WAKEUP_EVENT    <= 1'b1;
            end else if (cyc_reg == CYC_W'(TICK_CYCLES_P - 1)) begin
              cyc_reg   <= '0;
              ticks_reg <= ticks_reg + TIMER_W'(1);
            end else begin
              cyc_reg <= cyc_reg + CYC_W'(1);
            end
          end
          TIMER_DONE: begin
            timer_state_reg <= TIMER_DONE;
          end
          default: begin
            timer_state_reg <= TIMER_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== pwt_host.sv
// host end: Avalon-MM slave that turns orders into serial command words
// assumes an Avalon master on CLOCK and the device on the far link
`timescale 1ns/1ps
`default_nettype none
module pwt_host
  import pwt_pkg::*;
#(
  parameter int HALF_P = SCK_HALF_CYCLES
) (
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  input  wire logic [ADDR_W-1:0] ADDRESS,
  input  wire logic              READ,
  input  wire logic              WRITE,
  input  wire logic [31:0]       WRITEDATA,
  output logic      [31:0]       READDATA,
  output logic                   WAITREQUEST,
  pwt_link_if.host               LINK
);

  // ==========================================================
  // word fix-up before sending
  function automatic logic [WORD_W-1:0] fix_word(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] r;
    r = w;
    if (w[CODE_HI:POWER_CODE_LO] == POWER_CODE && w[BIT_BB]) begin
      r[BIT_OSC] = 1'b1;
    end
    if (w[CODE_HI:INTERVAL_CODE_LO] == INTERVAL_CODE &&
        w[EXP_HI:EXP_LO] > EXP_MAX) begin
      r[EXP_HI:EXP_LO] = EXP_MAX;
    end
    // multiplier passes with its whole byte
    return r;
  endfunction

  // ==========================================================
  // Avalon slave
  pwt_link_state_type    state_reg;
  logic                  pending_reg;
  logic                  gap_reg;
  logic [WORD_W-1:0]     last_power_reg;
  logic                  link_free;
  logic                  req;
  logic                  accept;
  logic                  ok;
  logic                  do_cmd;
  logic                  do_rearm;
  logic [WORD_W-1:0]     cmd_word;

  // a full half bit of deselect must pass before a new frame starts
  assign link_free = state_reg == LINK_IDLE && !pending_reg && !gap_reg;
  assign req       = READ || WRITE;
  // writes stall while a word is still on the wire
  assign ok        = READ || link_free;
  assign accept    = req && !WAITREQUEST;
  assign do_cmd    = accept && WRITE && ADDRESS == REG_CMD;
  assign do_rearm  = accept && WRITE && ADDRESS == REG_REARM;
  assign cmd_word  = fix_word(WRITEDATA[WORD_W-1:0]);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      WAITREQUEST <= 1'b1;
      READDATA    <= '0;
    end else begin
      WAITREQUEST <= !(req && WAITREQUEST && ok);
      if (req && WAITREQUEST && ok) begin
        case (ADDRESS)
          REG_STATUS:     READDATA <= {30'h0, pending_reg,
                                       state_reg != LINK_IDLE};
          REG_LAST_POWER: READDATA <= {16'h0, last_power_reg};
          default:        READDATA <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      last_power_reg <= POWER_RESET;
    end else if (do_cmd &&
                 cmd_word[CODE_HI:POWER_CODE_LO] == POWER_CODE) begin
      last_power_reg <= cmd_word;
    end else if (do_rearm) begin
      last_power_reg[BIT_WUT] <= 1'b1;
    end
  end

  // ==========================================================
  // bit clock divider
  logic [7:0]            half_cnt_reg;
  logic                  tick;

  assign tick = half_cnt_reg == 8'(HALF_P - 1);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      half_cnt_reg <= '0;
    end else if (tick || do_cmd || do_rearm) begin
      // restart on frame load so the lead before the first rise is full
      half_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  // ==========================================================
  // link shifter, msb first
  logic [WORD_W-1:0]     shift_reg;
  logic [WORD_W-1:0]     second_reg;
  logic [BIT_CNT_W-1:0]  bits_reg;
  logic                  sck_reg;
  logic                  sdi_reg;
  logic                  sel_n_reg;
  logic [WORD_W-1:0]     off_word;

  assign off_word = last_power_reg & ~(WORD_W'(1) << BIT_WUT);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_reg   <= LINK_IDLE;
      pending_reg <= 1'b0;
      shift_reg   <= '0;
      second_reg  <= '0;
      bits_reg    <= '0;
      sck_reg     <= 1'b0;
      sdi_reg     <= 1'b0;
      sel_n_reg   <= 1'b1;
      gap_reg     <= 1'b0;
    end else begin
      case (state_reg)
        LINK_IDLE: begin
          if (tick) begin
            gap_reg <= 1'b0;
          end
          if (do_cmd || do_rearm) begin
            // rearm sends the enable cleared, then set
            shift_reg   <= do_cmd ? cmd_word : off_word;
            sdi_reg     <= do_cmd ? cmd_word[CODE_HI] : off_word[CODE_HI];
            second_reg  <= off_word | (WORD_W'(1) << BIT_WUT);
            pending_reg <= do_rearm;
            bits_reg    <= '0;
            sel_n_reg   <= 1'b0;
            state_reg   <= LINK_LOW;
          end else if (pending_reg && tick) begin
            // deselect lasted one half bit, enough for the device
            shift_reg   <= second_reg;
            sdi_reg     <= second_reg[CODE_HI];
            pending_reg <= 1'b0;
            bits_reg    <= '0;
            sel_n_reg   <= 1'b0;
            state_reg   <= LINK_LOW;
          end
        end
        LINK_LOW: begin
          if (tick) begin
            sck_reg   <= 1'b1;
            state_reg <= LINK_HIGH;
          end
        end
        LINK_HIGH: begin
          if (tick) begin
            sck_reg <= 1'b0;
            if (bits_reg == LAST_BIT) begin
              state_reg <= LINK_END;
            end else begin
              bits_reg  <= bits_reg + BIT_CNT_W'(1);
              shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
              sdi_reg   <= shift_reg[WORD_W-2];
              state_reg <= LINK_LOW;
            end
          end
        end
        LINK_END: begin
          if (tick) begin
            sel_n_reg <= 1'b1;
            gap_reg   <= 1'b1;
            state_reg <= LINK_IDLE;
          end
        end
        default: begin
          state_reg <= LINK_IDLE;
        end
      endcase
    end
  end

  assign LINK.sck      = sck_reg;
  assign LINK.sdi      = sdi_reg;
  assign LINK.select_n = sel_n_reg;

endmodule
`default_nettype wire

// ===== pwt_link_properties.sv
// wire checks on the serial link between host end and device end
// assumes the link signals sampled on CLOCK, frames made by the host end
`timescale 1ns/1ps
`default_nettype none
module pwt_link_properties #(
  parameter int HALF_P = 8
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic sck,
  input wire logic sdi,
  input wire logic select_n
);
  // ==========================================================
  // helper state
  logic        sck_q;
  logic        sel_q;
  logic [15:0] run_len;
  logic [4:0]  bits;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
    end else begin
      sck_q <= sck;
      sel_q <= select_n;
    end
  end

  // run length of the current sck level
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) run_len <= 16'h0001;
    else if (sck != sck_q) run_len <= 16'h0001;
    else run_len <= run_len + 16'h0001;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) bits <= 5'h00;
    else if (select_n) bits <= 5'h00;
    else if (sck && !sck_q) bits <= bits + 5'h01;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_idle_clock_low: assert property (select_n |-> !sck)
    else $error("sck high outside a frame");
  a_sdi_steady_high: assert property (sck && sck_q |-> $stable(sdi))
    else $error("sdi moved while sck high");
  a_sck_high_time: assert property (!sck && sck_q |-> run_len == HALF_P)
    else $error("sck high phase has wrong length");
  a_sck_low_time: assert property (
    sck && !sck_q && bits != 5'h00 |-> run_len == HALF_P)
    else $error("sck low phase has wrong length");
  a_frame_sixteen: assert property (select_n && !sel_q |-> bits == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_bits_bounded: assert property (!select_n |-> bits <= 5'h10)
    else $error("more than sixteen sck rises in a frame");
  a_lead_time: assert property (
    $fell(select_n) |-> !sck [*7] ##[1:2] sck)
    else $error("first sck rise not one half period after select");
  a_frame_gap: assert property (
    select_n && !sel_q |-> select_n [*8])
    else $error("frames too close together");
  a_frame_span: assert property (
    $fell(select_n) |-> ##[255:275] select_n)
    else $error("frame length out of range");
endmodule
`default_nettype wire

// ===== power_enable_and_wakeup_timer_test.sv
// self-checking bench: Avalon master on the host end, device on the link
// assumes short timer counts; a second device is driven by hand-made frames
`timescale 1ns/1ps
`default_nettype none
module power_enable_and_wakeup_timer_test;
  import pwt_pkg::*;
  localparam int TICK = 4;
  localparam int OFF = 3;
  localparam int LIMIT = 30000;
  logic clock, nrst, rd, wr, tx_on, waitreq, mon_sck;
  logic [3:0] address;
  logic [31:0] wdata, rdata, d;
  logic [15:0] pw, iw, pw2, mon_word, ew;
  logic [9:0] outs;
  logic wake_on, wake_ev;
  int errors = 0, check_count = 0, cyc = 0, n;
  logic [7:0] tbl [8] = '{8'h01, 8'h80, 8'h40, 8'h20, 8'h10, 8'h09, 8'h07, 8'h00};

  pwt_link_if l1();
  pwt_link_if l2();
  pwt_host #(.HALF_P(8)) i_pwt_host (.CLOCK(clock), .NRST(nrst),
    .ADDRESS(address), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
    .READDATA(rdata), .WAITREQUEST(waitreq), .LINK(l1.host));
  pwt_device #(.TICK_CYCLES_P(TICK), .OFFSET_CYCLES_P(OFF)) i_pwt_device (
    .CLOCK(clock), .NRST(nrst), .LINK(l1.dev), .TX_DATA_REG_ON(tx_on),
    .RX_CHAIN_ON(outs[9]), .BASEBAND_ON(outs[8]), .TX_CHAIN_ON(outs[7]),
    .TX_SENDING(outs[6]), .SYNTH_ON(outs[5]), .CRYSTAL_OSC_RUN(outs[4]),
    .BATTERY_DET_ON(outs[3]), .WAKEUP_TIMER_ON(outs[2]),
    .CLOCK_OUT_RUN(outs[1]), .FULL_SLEEP(outs[0]),
    .WAKEUP_EVENT(wake_ev), .POWER_WORD(pw), .INTERVAL_WORD(iw));
  // second device sees hand-made frames: one cut short at twelve bits, one full sixteen-bit word
  pwt_device #(.TICK_CYCLES_P(TICK), .OFFSET_CYCLES_P(OFF)) i_pwt_device_2 (
    .CLOCK(clock), .NRST(nrst), .LINK(l2.dev), .TX_DATA_REG_ON(1'b0),
    .RX_CHAIN_ON(), .BASEBAND_ON(), .TX_CHAIN_ON(), .TX_SENDING(),
    .SYNTH_ON(), .CRYSTAL_OSC_RUN(), .BATTERY_DET_ON(),
    .WAKEUP_TIMER_ON(), .CLOCK_OUT_RUN(), .FULL_SLEEP(),
    .WAKEUP_EVENT(), .POWER_WORD(pw2), .INTERVAL_WORD());
  pwt_link_properties #(.HALF_P(8)) i_pwt_link_properties (.CLOCK(clock),
    .NRST(nrst), .sck(l1.sck), .sdi(l1.sdi), .select_n(l1.select_n));
  assign wake_on = outs[2];

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ==========================================================
  // shared tasks
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      conclude();
    end
  end

  // wire monitor: bits taken at each sck rise, first bit ends up on top
  always @(posedge clock) begin
    mon_sck <= l1.sck;
    if (l1.sck && !mon_sck && !l1.select_n) mon_word <= {mon_word[14:0], l1.sdi};
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic av_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    wdata <= v;
    wr <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic av_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    address <= a;
    rd <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
  endtask

  // waits on the stored word, bounded; a miss shows up in the next compare
  task automatic wait_word(input logic sel, input logic [15:0] w);
    int k;
    k = 0;
    while ((sel ? iw : pw) !== w && k < 600) begin
      @(posedge clock);
      k++;
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic send2(input logic [15:0] w, input int bits);
    @(posedge clock);
    l2.select_n <= 1'b0;
    for (int i = 0; i < bits; i++) begin
      l2.sdi <= w[15-i];
      repeat (8) @(posedge clock);
      l2.sck <= 1'b1;
      repeat (8) @(posedge clock);
      l2.sck <= 1'b0;
    end
    repeat (8) @(posedge clock);
    l2.select_n <= 1'b1;
    l2.sdi <= ~l2.sdi;
    repeat (8) @(posedge clock);
  endtask

  function automatic logic [9:0] exp_out(input logic [15:0] w, input logic t);
    logic bb, syn, osc;
    bb = w[6] | w[7];
    syn = w[4] | w[7] | w[5];
    osc = w[3] | w[7] | w[5] | !w[0];
    return {w[7], bb, w[5], w[5] & t, syn, osc, w[2], w[1], !w[0],
            !(osc | bb | syn | w[2])};
  endfunction

  // ==========================================================
  // tests
  initial begin
    nrst = 1'b0; rd = 1'b0; wr = 1'b0; tx_on = 1'b0;
    address = 4'h0; wdata = 32'h0;
    l2.sck = 1'b0; l2.sdi = 1'b0; l2.select_n = 1'b1;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    check(pw, 16'h8208);
    check(iw, 16'hE196);
    check(outs, exp_out(16'h8208, 1'b0));
    av_read(REG_LAST_POWER, d);
    check(d, 32'h00008208);
    av_read(4'h2, d);
    check(d, 32'h0); // unmapped place reads zero
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      tx_on <= i[0];
      ew = {8'h82, tbl[i] | (tbl[i][6] ? 8'h08 : 8'h00)};
      av_write(REG_CMD, {16'h0, 8'h82, tbl[i]});
      wait_word(1'b0, ew);
      check(pw, ew);
      check(mon_word, ew);
      check(outs, exp_out(ew, i[0]));
    end
    $display("test power word done");
    av_write(REG_CMD, 32'h0000A0FF);
    repeat (350) @(posedge clock);
    check(mon_word, 16'hA0FF);
    check(pw, 16'h8200);
    check(iw, 16'hE196);
    send2(16'h82FF, 12);
    repeat (10) @(posedge clock);
    check(pw2, 16'h8208);
    send2(16'h82A5, 16);
    repeat (10) @(posedge clock);
    check(pw2, 16'h82A5);
    $display("test refused words done");
    // back to back: the rearm write stalls behind the interval frame
    av_write(REG_CMD, 32'h0000E103);
    av_write(REG_REARM, 32'h0);
    check(iw, 16'hE103);
    av_read(REG_STATUS, d);
    check(d, 32'h00000003);
    av_read(REG_LAST_POWER, d);
    check(d, 32'h00008202);
    n = 0;
    while (wake_on !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (wake_ev !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(n >= OFF + 6 * TICK - 1 && n <= OFF + 6 * TICK + 4, 1'b1);
    n = 0;
    repeat (150) begin
      @(posedge clock);
      if (wake_ev === 1'b1) n++;
    end
    check(n, 0);
    av_write(REG_CMD, 32'h0000FFFF);
    wait_word(1'b1, 16'hFDFF);
    check(iw, 16'hFDFF);
    check(mon_word, 16'hFDFF);
    $display("test wake-up timer done");
    conclude();
  end
endmodule
`default_nettype wire
